// ### local_bus_arb_pkg.sv
// Constants and carrier types for the local bus arbitration and burst interface
package local_bus_arb_pkg;
   localparam int unsigned ADDR_W        = 32;
   localparam int unsigned REG_ADDR_W    = 12;
   localparam int unsigned BEAT_W        = 3;
   localparam logic [2:0]  READ_BEATS    = 3'h4;
   localparam logic [2:0]  MAX_BEATS     = 3'h4;
   localparam logic [2:0]  MIN_BEATS     = 3'h1;
   localparam logic [3:0]  LINE_OFS_ZERO = 4'h0;
   localparam int unsigned LINE_OFS_W    = 4;
   localparam logic [1:0]  SEL_WINDOW    = 2'h3;
   localparam logic        LEGACY_LEVEL  = 1'b0;

   typedef enum logic [2:0] {
      M_IDLE   = 3'b000,
      M_REQ    = 3'b001,
      M_GRANT  = 3'b010,
      M_ADDR   = 3'b011,
      M_DATA   = 3'b100,
      M_NEGATE = 3'b101
   } mst_state_t;

   typedef enum logic [1:0] {
      E_IDLE   = 2'b00,
      E_ASSERT = 2'b01,
      E_NEGATE = 2'b10
   } err_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              write;
      logic [BEAT_W-1:0] beats;
   } mst_cmd_t;

   typedef struct packed {
      logic       done;
      logic       error;
   } mst_status_t;
endpackage

// ### local_bus_arb_burst.sv
// Local bus arbitration, address, burst and bus error logic of the bridge
// Overview of operation
// - Register accesses decode only the low 12 address bits.
// - As master, address is driven out after a rising clock edge.
// - The bus owner holds bus busy low for its whole tenure.
// - Busy asserted from clock edge; driven high before release to tristate.
// - New personality asserts busy one clock after grant is received.
// - When not driving busy, the line is sampled every rising edge.
// - Grant input is sampled on the rising clock edge.
// - Master burst writes flag second-to-last beat; two to four beats (code takes the count from MST_CMD_I.beats unchecked).
// - Master burst reads are aligned four-beat lines, cut short only by a bus error.
// - As slave, burst flag marks second-to-last beat; two to four beats.
// - Burst pin low at reset selects legacy master personality.
// - Bus error driven only as slave, negated before tristate.
// - As master, bus error is sampled each rising edge.
// - Bus request asserted for ownership, released from a clock edge.
`timescale 1ns/1ps
`default_nettype none
module local_bus_arb_burst
   import local_bus_arb_pkg::*;
(
   input  wire logic                  CORE_CLK_I,
   input  wire logic                  RESETN_I,
   input  wire logic                  MST_REQ_I,
   input  wire mst_cmd_t              MST_CMD_I,
   output var  logic                  MST_BUSY_O,
   output var  mst_status_t           MST_STATUS_O,
   output var  logic                  LEGACY_MODE_O,
   input  wire logic                  SLV_ERR_I,
   output var  logic                  REG_ACCESS_O,
   output var  logic [REG_ADDR_W-1:0] REG_ADDR_O,
   output var  logic                  SLV_LAST_O,
   input  wire logic                  BUS_GRANT_N_I,
   output var  logic                  BUS_REQUEST_N_O,
   input  wire logic                  BUS_BUSY_N_I,
   output var  logic                  BUS_BUSY_N_O,
   output var  logic                  BUS_BUSY_OE_O,
   input  wire logic [ADDR_W-1:0]     ADDR_I,
   output var  logic [ADDR_W-1:0]     ADDR_O,
   output var  logic                  ADDR_OE_O,
   input  wire logic                  BURST_IN_PROGRESS_N_I,
   output var  logic                  BURST_IN_PROGRESS_N_O,
   output var  logic                  BURST_IN_PROGRESS_OE_O,
   input  wire logic                  BUS_ERROR_N_I,
   output var  logic                  BUS_ERROR_N_O,
   output var  logic                  BUS_ERROR_OE_O,
   input  wire logic                  TRANSFER_START_N_I,
   input  wire logic                  REGISTER_SELECT_N_I,
   input  wire logic                  TRANSFER_ACK_N_I
);

   // Personality capture
   logic       strap_done_q;
   logic       legacy_q;

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         strap_done_q <= 1'b0;
         legacy_q     <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         legacy_q     <= (BURST_IN_PROGRESS_N_I == LEGACY_LEVEL);
      end
   end

   // Master sequencer
   mst_state_t        m_state_q, m_state_d;
   mst_cmd_t          cmd_q;
   logic [BEAT_W-1:0] beats_left_q, beats_left_d;
   mst_status_t       status_q, status_d;

   wire bus_free   = !BUS_GRANT_N_I && BUS_BUSY_N_I;
   wire beat_ack   = (m_state_q == M_DATA) && !TRANSFER_ACK_N_I;
   wire mst_err    = (m_state_q == M_DATA) && !BUS_ERROR_N_I;
   wire last_ack   = beat_ack && (beats_left_q == MIN_BEATS);
   wire start_ok   = (m_state_q == M_IDLE) && MST_REQ_I && strap_done_q;
   wire [BEAT_W-1:0] req_beats = MST_CMD_I.write ? MST_CMD_I.beats : READ_BEATS;
   wire [ADDR_W-1:0] req_addr  = MST_CMD_I.write ? MST_CMD_I.addr :
      {MST_CMD_I.addr[ADDR_W-1:LINE_OFS_W], LINE_OFS_ZERO};

   always_comb begin
      m_state_d = m_state_q;
      unique case (m_state_q)
         M_IDLE:   if (start_ok) m_state_d = M_REQ;
         M_REQ:    if (bus_free) m_state_d = legacy_q ? M_ADDR : M_GRANT;
         M_GRANT:  m_state_d = M_ADDR;
         M_ADDR:   m_state_d = M_DATA;
         M_DATA:   if (mst_err || last_ack) m_state_d = M_NEGATE;
         M_NEGATE: m_state_d = M_IDLE;
         default:  m_state_d = M_IDLE;
      endcase
   end

   assign beats_left_d = start_ok ? req_beats :
                         beat_ack ? beats_left_q - MIN_BEATS : beats_left_q;
   assign status_d.done  = (m_state_q == M_DATA) && (m_state_d == M_NEGATE);
   assign status_d.error = mst_err;

   wire own_d   = (m_state_d == M_ADDR) || (m_state_d == M_DATA);
   wire drive_d = own_d || (m_state_d == M_NEGATE);

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         m_state_q    <= M_IDLE;
         cmd_q        <= '0;
         beats_left_q <= '0;
         status_q     <= '0;
      end else begin
         m_state_q    <= m_state_d;
         beats_left_q <= beats_left_d;
         status_q     <= status_d;
         if (start_ok) begin
            cmd_q.addr  <= req_addr;
            cmd_q.write <= MST_CMD_I.write;
            cmd_q.beats <= req_beats;
         end
      end
   end

   // Master pin flops
   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         BUS_REQUEST_N_O        <= 1'b1;
         BUS_BUSY_N_O           <= 1'b1;
         BUS_BUSY_OE_O          <= 1'b0;
         ADDR_O                 <= '0;
         ADDR_OE_O              <= 1'b0;
         BURST_IN_PROGRESS_N_O  <= 1'b1;
         BURST_IN_PROGRESS_OE_O <= 1'b0;
         MST_BUSY_O             <= 1'b0;
         MST_STATUS_O           <= '0;
         LEGACY_MODE_O          <= 1'b0;
      end else begin
         BUS_REQUEST_N_O        <= !(m_state_d == M_REQ);
         BUS_BUSY_N_O           <= !own_d;
         BUS_BUSY_OE_O          <= drive_d;
         ADDR_O                 <= cmd_q.addr;
         ADDR_OE_O              <= own_d;
         BURST_IN_PROGRESS_N_O  <= !(own_d && (beats_left_d > MIN_BEATS));
         BURST_IN_PROGRESS_OE_O <= drive_d;
         MST_BUSY_O             <= (m_state_d != M_IDLE);
         MST_STATUS_O           <= status_d;
         LEGACY_MODE_O          <= legacy_q;
      end
   end

   // Slave address phase and burst tracking
   logic                  slv_act_q;
   logic                  slv_sel_q;
   logic [1:0]            slv_win_q;
   logic [REG_ADDR_W-1:0] slv_addr_q;

   wire slv_start = !TRANSFER_START_N_I && (m_state_q == M_IDLE || m_state_q == M_REQ);
   wire sel_hit   = !REGISTER_SELECT_N_I && (slv_start ||
                    (slv_act_q && !slv_sel_q && slv_win_q < SEL_WINDOW));
   wire slv_beat  = slv_sel_q && !TRANSFER_ACK_N_I;
   wire slv_last  = slv_beat && BURST_IN_PROGRESS_N_I;
   wire [REG_ADDR_W-1:0] slv_addr_d = slv_start ? ADDR_I[REG_ADDR_W-1:0] : slv_addr_q;
   wire slv_act_d = slv_start || (slv_act_q && !slv_last &&
                    (slv_sel_q || sel_hit || slv_win_q < SEL_WINDOW));
   wire [1:0] slv_win_d = slv_start ? 2'h0 :
                          (slv_act_q && slv_win_q < SEL_WINDOW) ? slv_win_q + 2'h1 : slv_win_q;

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         slv_act_q    <= 1'b0;
         slv_sel_q    <= 1'b0;
         slv_win_q    <= '0;
         slv_addr_q   <= '0;
         REG_ACCESS_O <= 1'b0;
         REG_ADDR_O   <= '0;
         SLV_LAST_O   <= 1'b0;
      end else begin
         slv_act_q    <= slv_act_d;
         slv_sel_q    <= slv_act_d && (sel_hit || (slv_sel_q && !slv_start));
         slv_win_q    <= slv_win_d;
         slv_addr_q   <= slv_addr_d;
         REG_ACCESS_O <= sel_hit;
         REG_ADDR_O   <= slv_addr_d;
         SLV_LAST_O   <= slv_last;
      end
   end

   // Slave bus error driver
   err_state_t e_state_q, e_state_d;

   always_comb begin
      e_state_d = e_state_q;
      unique case (e_state_q)
         E_IDLE:   if (SLV_ERR_I && slv_sel_q) e_state_d = E_ASSERT;
         E_ASSERT: e_state_d = E_NEGATE;
         E_NEGATE: e_state_d = E_IDLE;
         default:  e_state_d = E_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         e_state_q      <= E_IDLE;
         BUS_ERROR_N_O  <= 1'b1;
         BUS_ERROR_OE_O <= 1'b0;
      end else begin
         e_state_q      <= e_state_d;
         BUS_ERROR_N_O  <= !(e_state_d == E_ASSERT);
         BUS_ERROR_OE_O <= (e_state_d != E_IDLE);
      end
   end

   // Checks
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);

   a_busy_after_grant: assert property (
      (m_state_q == M_REQ && bus_free && !legacy_q) |=> !BUS_BUSY_OE_O ##1 !BUS_BUSY_N_O)
      else $error("busy not asserted one clock after grant");
   a_busy_needs_grant: assert property (
      $fell(BUS_BUSY_N_O) |-> !$past(BUS_GRANT_N_I, 2) || !$past(BUS_GRANT_N_I, 1))
      else $error("busy asserted without grant");
   a_busy_negate_first: assert property (
      $fell(BUS_BUSY_OE_O) |-> $past(BUS_BUSY_N_O) && $past(BUS_BUSY_OE_O))
      else $error("busy released without negation");
   a_busy_held_owner: assert property (
      (m_state_q == M_DATA) |-> BUS_BUSY_OE_O && !BUS_BUSY_N_O)
      else $error("busy high while owning bus");
   a_read_four_beats: assert property (
      (m_state_q == M_ADDR && !cmd_q.write) |-> beats_left_q == READ_BEATS
                                               && cmd_q.addr[LINE_OFS_W-1:0] == LINE_OFS_ZERO)
      else $error("read burst not aligned four beats");
   a_burst_flag_end: assert property (
      (beat_ack && beats_left_q == 3'h2 && !mst_err) |=> BURST_IN_PROGRESS_N_O)
      else $error("burst flag not negated after second last beat");
   a_error_slave_only: assert property (
      !BUS_ERROR_N_O |-> BUS_ERROR_OE_O ##1 (BUS_ERROR_N_O && BUS_ERROR_OE_O) ##1 !BUS_ERROR_OE_O)
      else $error("bus error not negated before tristate");
   a_master_error_end: assert property (
      mst_err |=> MST_STATUS_O.error ##1 !BUS_BUSY_OE_O)
      else $error("master error not terminating cycle");
   a_reg_addr_low: assert property (
      slv_start |=> REG_ADDR_O == $past(ADDR_I[REG_ADDR_W-1:0]))
      else $error("register address not low bits");
   a_mode_stable: assert property (
      strap_done_q |=> $stable(legacy_q))
      else $error("personality changed after reset");
   a_request_release: assert property (
      (m_state_q == M_REQ && bus_free) |=> BUS_REQUEST_N_O)
      else $error("request not released after grant");

   c_write_burst: cover property (M_DATA == m_state_q && cmd_q.write && cmd_q.beats == 3'h3
                                  ##[1:20] status_q.done);
   c_read_burst:  cover property (m_state_q == M_ADDR && !cmd_q.write ##[1:20] status_q.done);
   c_slave_last:  cover property (REG_ACCESS_O ##[1:20] SLV_LAST_O);
   c_slave_error: cover property (e_state_q == E_ASSERT);
endmodule
`default_nettype wire

// ### local_bus_partner.sv
// Arbiter and bus slave model on the far side of the local bus interface
`timescale 1ns/1ps
`default_nettype none
module local_bus_partner (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic req_n_i,
   input  wire logic busy_n_i,
   input  wire logic dut_oe_i,
   input  wire logic hold_i,
   input  wire logic slow_i,
   input  wire logic err_i,
   output var  logic grant_n_o,
   output var  logic busy_n_o,
   output var  logic ack_n_o,
   output var  logic err_n_o
);
   logic ph_q;
   wire  owned = dut_oe_i && !busy_n_i;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         grant_n_o <= 1'b1;
         busy_n_o  <= 1'b1;
         ack_n_o   <= 1'b1;
         err_n_o   <= 1'b1;
         ph_q      <= 1'b0;
      end else begin
         ph_q      <= !ph_q;
         busy_n_o  <= !hold_i;
         grant_n_o <= req_n_i | (slow_i & !ph_q);
         ack_n_o   <= !(owned && !err_i && !(slow_i && ph_q));
         err_n_o   <= !(owned && err_i && err_n_o);
      end
   end
endmodule
`default_nettype wire

// ### local_bus_arbitration_burst_if_bench.sv
// Self-checking bench for the local bus arbitration and burst logic
`timescale 1ns/1ps
`default_nettype none
module local_bus_arbitration_burst_if_bench;
   import local_bus_arb_pkg::*;
   logic clk = 0, rstn = 0, mreq = 0, slv_err = 0, ts = 1, sel = 1, tack = 1, tbip = 1;
   logic hold = 0, slow = 0, perr = 0, dn, er, viol, acc, lst;
   mst_cmd_t cmd = '0;
   logic [31:0] taddr = '0, ma;
   int acks, blow, bad_count = 0, compares = 0;
   wire logic p_grant, p_busy, p_ack, p_err, req_n, b_oe, b_n, e_oe, e_n, bp_oe, bp_n, a_oe;
   wire logic [31:0] a_o;
   wire mst_status_t st;
   wire logic busy_n = (b_oe ? b_n : 1'b1) & p_busy;
   wire logic err_n = (e_oe ? e_n : 1'b1) & p_err;
   wire logic bip_n = bp_oe ? bp_n : tbip;
   wire logic [31:0] addr = a_oe ? a_o : taddr;
   wire logic ack_n = p_ack & tack;
   always #2.5 clk = !clk;
   local_bus_arb_burst u_dut (.CORE_CLK_I(clk), .RESETN_I(rstn), .MST_REQ_I(mreq),
      .MST_CMD_I(cmd), .MST_BUSY_O(), .MST_STATUS_O(st), .LEGACY_MODE_O(),
      .SLV_ERR_I(slv_err), .REG_ACCESS_O(), .REG_ADDR_O(), .SLV_LAST_O(),
      .BUS_GRANT_N_I(p_grant), .BUS_REQUEST_N_O(req_n), .BUS_BUSY_N_I(busy_n),
      .BUS_BUSY_N_O(b_n), .BUS_BUSY_OE_O(b_oe), .ADDR_I(addr), .ADDR_O(a_o),
      .ADDR_OE_O(a_oe), .BURST_IN_PROGRESS_N_I(bip_n), .BURST_IN_PROGRESS_N_O(bp_n),
      .BURST_IN_PROGRESS_OE_O(bp_oe), .BUS_ERROR_N_I(err_n), .BUS_ERROR_N_O(e_n),
      .BUS_ERROR_OE_O(e_oe), .TRANSFER_START_N_I(ts), .REGISTER_SELECT_N_I(sel),
      .TRANSFER_ACK_N_I(ack_n));
   local_bus_partner u_far (.clk_i(clk), .rstn_i(rstn), .req_n_i(req_n), .busy_n_i(busy_n),
      .dut_oe_i(b_oe), .hold_i(hold), .slow_i(slow), .err_i(perr), .grant_n_o(p_grant),
      .busy_n_o(p_busy), .ack_n_o(p_ack), .err_n_o(p_err));
   always @(posedge clk) begin
      if (b_oe && !b_n && !ack_n) acks++;
      if (b_oe && !b_n && !ack_n && bp_oe && !bp_n) blow++;
      if (b_oe && !b_n && a_oe) ma = a_o;
      if (b_oe && !b_n && !p_busy) viol = 1;
      if (st.done) dn = 1;
      if (st.error) er = 1;
      if (u_dut.REG_ACCESS_O) acc = 1;
      if (u_dut.SLV_LAST_O) lst = 1;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_sim;
      $display("bad_count=%0d compares=%0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic rst(input logic lvl);
      @(posedge clk);
      rstn <= 0;
      tbip <= lvl;
      repeat (20) @(posedge clk);
      rstn <= 1;
      repeat (3) @(posedge clk);
      chk(u_dut.LEGACY_MODE_O, !lvl);
      tbip <= !lvl;
      repeat (3) @(posedge clk);
      chk(u_dut.LEGACY_MODE_O, !lvl);
      tbip <= 1;
   endtask
   task automatic mst(input logic [31:0] a, input logic w, input logic [2:0] b,
                      input logic e, input int h, input logic s);
      int n;
      acks = 0; blow = 0; dn = 0; er = 0; viol = 0; n = 0;
      @(posedge clk);
      hold <= (h > 0);
      slow <= s;
      perr <= e;
      mreq <= 1;
      cmd <= {a, w, b};
      do @(posedge clk); while (u_dut.MST_BUSY_O !== 1'b1);
      mreq <= 0;
      repeat (h) @(posedge clk);
      hold <= 0;
      while (dn !== 1'b1 && er !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
      chk(dn, 1'b1);
      chk(er, e);
      chk(viol, 0);
      chk(b_oe, 0);
      chk(req_n, 1);
      if (!e) chk(acks, w ? b : 4);
      if (!e) chk(ma, w ? a : {a[31:4], 4'h0});
      if (w && !e) chk(blow, b - 1);
   endtask
   task automatic slv(input int d, input logic e);
      acc = 0;
      lst = 0;
      @(posedge clk);
      ts <= 0;
      taddr <= 32'hfedcba5c;
      repeat (d) begin
         @(posedge clk);
         ts <= 1;
      end
      sel <= 0;
      @(posedge clk);
      ts <= 1;
      slv_err <= e;
      tack <= e;
      tbip <= e;
      @(posedge clk);
      slv_err <= 0;
      if (e) begin
         #1 chk({e_oe, e_n}, 2'h2);
         @(posedge clk);
         #1 chk({e_oe, e_n}, 2'h3);
         @(posedge clk);
         #1 chk(e_oe, 0);
      end else begin
         @(posedge clk);
         tbip <= 1;
         @(posedge clk);
         tack <= 1;
         repeat (2) @(posedge clk);
         chk(lst, d < 4);
      end
      sel <= 1;
      tbip <= 1;
      @(posedge clk);
      chk(acc, d < 4);
      chk(u_dut.REG_ADDR_O, 12'ha5c);
   endtask
   initial begin
      #100000;
      bad_count++;
      end_sim;
   end
   initial begin
      rst(1'b0);
      mst(32'h40000124, 1, 3'h2, 0, 0, 0);
      rst(1'b1);
      for (int b = 1; b <= 4; b++) mst(32'h10000010 + b, 1, b[2:0], 0, 0, b[0]);
      mst(32'h20000007, 0, 3'h1, 0, 0, 1);
      mst(32'h30000100, 1, 3'h3, 0, 6, 0);
      mst(32'h50000200, 1, 3'h2, 1, 0, 0);
      for (int d = 0; d <= 4; d++) slv(d, 0);
      slv(1, 1);
      end_sim;
   end
endmodule
`default_nettype wire
